/* File: core/pause_slot_timer.sv */
`timescale 1ns/1ns
`include "tx_pause_params.svh"

module pause_slot_timer (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Control.
	input  wire logic        tick_i,
	input  wire logic        req_i,
	input  wire logic        en_i,
	input  wire logic        resend_i,
	input  wire logic [15:0] refresh_i,
	input  wire logic        sent_i,
	// Status.
	output logic             pending_o
);

	logic        active_q;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic        pending_q;
	logic        pending_d;

	wire active = req_i & en_i;
	wire start  = active & ~active_q;
	wire expire = active & active_q & tick_i & (cnt_q <= 16'd1);
	wire set    = start | (resend_i & active) | expire;

	// Reload on start, on resend and on every expiry, so the refresh interval restarts.
	assign cnt_d = !active ? 16'd0 :
		(start | resend_i | expire) ? refresh_i :
		(tick_i && cnt_q != 16'd0) ? cnt_q - 16'd1 : cnt_q;

	// A new reason to send beats the acknowledge of the frame just built.
	assign pending_d = set ? 1'b1 :
		(sent_i | ~en_i) ? 1'b0 : pending_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_q  <= 1'b0;
			cnt_q     <= 16'd0;
			pending_q <= 1'b0;
		end else begin
			active_q  <= active;
			cnt_q     <= cnt_d;
			pending_q <= pending_d;
		end
	end

	assign pending_o = pending_q;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_start_pend;
		start |=> pending_q;
	endproperty
	a_start_pend: assert property (p_start_pend) else $error("request did not raise pending");

	property p_dis_clear;
		!en_i |=> !pending_q;
	endproperty
	a_dis_clear: assert property (p_dis_clear) else $error("pending while disabled");

	property p_resend_reload;
		(resend_i && active) |=> pending_q && cnt_q == $past(refresh_i);
	endproperty
	a_resend_reload: assert property (p_resend_reload) else $error("resend missed reload");

	property p_expire_pend;
		expire |=> pending_q && cnt_q == $past(refresh_i);
	endproperty
	a_expire_pend: assert property (p_expire_pend) else $error("refresh expiry lost");

endmodule

/* File: core/tx_pause_frame_generator.sv */
`timescale 1ns/1ns
`include "tx_pause_params.svh"

// How it works
// - Each enabled high request bit causes a pause frame with that index's quanta.
// - Index 8 sends a global frame; indices 0 to 7 send priority frames.
// - Frames are built and quanta used only while that index is enabled.
// - Resend retransmits the frame of every enabled, active request once the packet in flight ends.
// - Resend also reloads the retransmission counter of every index whose request is active.
// - Nine 16-bit quanta inputs; index 8 global, 0 to 7 priorities.
// - Nine 16-bit refresh timers set each index's retransmission interval.
// - Global frames carry the global address, ethertype and opcode settings.
// - Priority frames carry their own separate address, ethertype and opcode settings.
// - A nine-bit pulse marks each sent frame; bit 8 global.
// - Pulse unicast, multicast or broadcast for every packet transmitted.
// - Pulse a VLAN increment for each transmitted 802.1Q tagged packet.
// - Pulse an increment for each global pause frame sent.
// - Pulse an increment for each priority pause frame sent.
// - Enable, quanta 4 and 5 and frame fields come from registers when mapped.
module tx_pause_frame_generator
	import tx_pause_pkg::*;
#(
	parameter bit REG_MAP = 1'b1
) (
	// Clock and reset.
	input  wire logic             CLOCK_I,
	input  wire logic             SYS_RST_I,
	// Avalon-MM register slave.
	input  wire logic [5:0]       AVS_ADDRESS_I,
	input  wire logic             AVS_READ_I,
	input  wire logic             AVS_WRITE_I,
	input  wire logic [31:0]      AVS_WRITEDATA_I,
	input  wire logic [3:0]       AVS_BYTEENABLE_I,
	output logic      [31:0]      AVS_READDATA_O,
	output logic                  AVS_WAITREQUEST_O,
	// Flow-control requests.
	input  wire logic [8:0]       PAUSE_REQ_I,
	input  wire logic [8:0]       PAUSE_ENABLE_I,
	input  wire logic             RESEND_PAUSE_I,
	input  wire logic [8:0][15:0] PAUSE_QUANTA_I,
	input  wire logic [8:0][15:0] REFRESH_TIMER_I,
	// Frame fields used when the register map is absent.
	input  wire logic [47:0]      GLOBAL_FRAME_DEST_ADDR_I,
	input  wire logic [47:0]      GLOBAL_FRAME_SRC_ADDR_I,
	input  wire logic [15:0]      GLOBAL_ETHERTYPE_I,
	input  wire logic [15:0]      GLOBAL_OPCODE_I,
	input  wire logic [47:0]      PRIORITY_FRAME_DEST_ADDR_I,
	input  wire logic [47:0]      PRIORITY_FRAME_SRC_ADDR_I,
	input  wire logic [15:0]      PRIORITY_ETHERTYPE_I,
	input  wire logic [15:0]      PRIORITY_OPCODE_I,
	// User packet stream.
	input  wire logic [63:0]      USER_TDATA_I,
	input  wire logic [7:0]       USER_TKEEP_I,
	input  wire logic             USER_TVALID_I,
	input  wire logic             USER_TLAST_I,
	output logic                  USER_TREADY_O,
	// Stream toward the MAC.
	output logic      [63:0]      MAC_TDATA_O,
	output logic      [7:0]       MAC_TKEEP_O,
	output logic                  MAC_TVALID_O,
	output logic                  MAC_TLAST_O,
	input  wire logic             MAC_TREADY_I,
	// Statistics pulses.
	output logic      [8:0]       PAUSE_SENT_O,
	output logic                  STAT_UNICAST_O,
	output logic                  STAT_MULTICAST_O,
	output logic                  STAT_BROADCAST_O,
	output logic                  STAT_VLAN_O,
	output logic                  STAT_PAUSE_O,
	output logic                  STAT_USER_PAUSE_O
);

	function automatic logic [3:0] pick_index(input logic [8:0] v);
		logic [3:0] r;
		r = `GLOBAL_IDX;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		if (v[8]) begin
			r = `GLOBAL_IDX;
		end
		return r;
	endfunction

	function automatic logic [511:0] build_frame(input logic glob, input logic [2:0] idx,
		input logic [15:0] q, input logic [47:0] da, input logic [47:0] sa,
		input logic [15:0] et, input logic [15:0] op);
		logic [511:0] f;
		f = '0;
		for (int k = 0; k < 6; k++) begin
			f[8*k +: 8]      = da[47-8*k -: 8];
			f[48+8*k +: 8]   = sa[47-8*k -: 8];
		end
		f[96 +: 8]  = et[15:8];
		f[104 +: 8] = et[7:0];
		f[112 +: 8] = op[15:8];
		f[120 +: 8] = op[7:0];
		if (glob) begin
			f[128 +: 8] = q[15:8];
			f[136 +: 8] = q[7:0];
		end else begin
			f[136 +: 8]            = 8'h01 << idx;
			f[144 + 16*idx +: 8]   = q[15:8];
			f[152 + 16*idx +: 8]   = q[7:0];
		end
		return f;
	endfunction

	// Register slave: one wait cycle, then the access completes.
	logic [31:0] regs_q [0:`REG_COUNT-1];
	logic        ack_q;
	logic [31:0] rdata_q;

	wire       bus_req  = AVS_READ_I | AVS_WRITE_I;
	wire [3:0] reg_idx  = AVS_ADDRESS_I[5:2];
	wire       reg_wr   = AVS_WRITE_I & ack_q & (reg_idx < 4'(`REG_COUNT));

	assign AVS_WAITREQUEST_O = bus_req & ~ack_q;
	assign AVS_READDATA_O    = rdata_q;

	// Mapped settings replace the pins; the pins are then ignored.
	wire [8:0]  en_eff = REG_MAP ? regs_q[`REG_PAUSE_EN][8:0] : PAUSE_ENABLE_I;
	wire [47:0] gda = REG_MAP ? {regs_q[`REG_GDA_HI][15:0], regs_q[`REG_GDA_LO]}
		: GLOBAL_FRAME_DEST_ADDR_I;
	wire [47:0] gsa = REG_MAP ? {regs_q[`REG_GSA_HI][15:0], regs_q[`REG_GSA_LO]}
		: GLOBAL_FRAME_SRC_ADDR_I;
	wire [15:0] get = REG_MAP ? regs_q[`REG_GTYPE_OP][15:0] : GLOBAL_ETHERTYPE_I;
	wire [15:0] gop = REG_MAP ? regs_q[`REG_GTYPE_OP][31:16] : GLOBAL_OPCODE_I;
	wire [47:0] pda = REG_MAP ? {regs_q[`REG_PDA_HI][15:0], regs_q[`REG_PDA_LO]}
		: PRIORITY_FRAME_DEST_ADDR_I;
	wire [47:0] psa = REG_MAP ? {regs_q[`REG_PSA_HI][15:0], regs_q[`REG_PSA_LO]}
		: PRIORITY_FRAME_SRC_ADDR_I;
	wire [15:0] pet = REG_MAP ? regs_q[`REG_PTYPE_OP][15:0] : PRIORITY_ETHERTYPE_I;
	wire [15:0] pop = REG_MAP ? regs_q[`REG_PTYPE_OP][31:16] : PRIORITY_OPCODE_I;

	logic [8:0][15:0] quanta_eff;
	genvar g;
	generate
		for (g = 0; g < 9; g++) begin : g_quanta
			if (g == 4 || g == 5) begin : g_mapped
				assign quanta_eff[g] = !REG_MAP ? PAUSE_QUANTA_I[g] :
					regs_q[`REG_QUANTA45][16*(g-4) +: 16];
			end else begin : g_pin
				assign quanta_eff[g] = PAUSE_QUANTA_I[g];
			end
		end
	endgenerate

	// Quantum tick: the refresh timers count in pause quanta.
	logic [2:0] qcnt_q;
	wire        tick = (qcnt_q == 3'(`QUANTUM_CYCLES - 1));

	// Per-index pending state.
	logic [8:0] pending;
	logic [8:0] sent_ack;
	generate
		for (g = 0; g < 9; g++) begin : g_slot
			pause_slot_timer u_slot (
				.clk_i     (CLOCK_I),
				.rst_i     (SYS_RST_I),
				.tick_i    (tick),
				.req_i     (PAUSE_REQ_I[g]),
				.en_i      (en_eff[g]),
				.resend_i  (RESEND_PAUSE_I),
				.refresh_i (REFRESH_TIMER_I[g]),
				.sent_i    (sent_ack[g]),
				.pending_o (pending[g])
			);
		end
	endgenerate

	// Scheduler.
	sched_state_t state_q;
	sched_state_t state_d;
	frame_kind_t  kind_q;
	logic [3:0]   idx_q;
	logic [2:0]   wcnt_q;
	logic [511:0] frame_q;
	logic         second_q;
	logic         mcast_q;
	logic         bcast_q;
	logic         vlan_q;
	logic [63:0]  odata_q;
	logic [7:0]   okeep_q;
	logic         ovalid_q;
	logic         olast_q;
	logic [8:0]   sent_q;
	logic [5:0]   stat_q;

	wire [8:0] sel       = pending & en_eff;
	wire [3:0] sel_idx   = pick_index(sel);
	wire       sel_glob  = (sel_idx == `GLOBAL_IDX);
	wire       can_load  = ~ovalid_q | MAC_TREADY_I;
	// Pause frames wait for an idle gap and a free output word, so a resend never cuts a
	// user packet and the frame still waiting at the MAC keeps its own kind for the stats.
	wire       start_pause = (state_q == ST_IDLE) & (|sel) & can_load;
	wire       user_ok   = can_load & (((state_q == ST_IDLE) & ~(|sel)) | (state_q == ST_USER));
	wire       user_fire = user_ok & USER_TVALID_I;
	wire       pause_fire = (state_q == ST_PAUSE) & can_load;
	wire       pause_end = pause_fire & (wcnt_q == `LAST_WORD);
	wire       out_done  = ovalid_q & MAC_TREADY_I & olast_q;
	wire [47:0] sel_da   = sel_glob ? gda : pda;
	wire [511:0] new_frame = build_frame(sel_glob, sel_idx[2:0], quanta_eff[sel_idx], sel_da,
		sel_glob ? gsa : psa, sel_glob ? get : pet, sel_glob ? gop : pop);
	wire [31:0] status_word = {21'd0, state_q, pending};
	wire [31:0] rd_mux = (reg_idx < 4'(`REG_COUNT)) ? regs_q[reg_idx] :
		(reg_idx == `REG_STATUS) ? status_word : 32'd0;

	assign sent_ack      = pause_end ? 9'(9'd1 << idx_q) : 9'd0;
	assign USER_TREADY_O = user_ok;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start_pause) begin
					state_d = ST_PAUSE;
				end else if (user_fire && !USER_TLAST_I) begin
					state_d = ST_USER;
				end
			end
			ST_USER: begin
				if (user_fire && USER_TLAST_I) begin
					state_d = ST_IDLE;
				end
			end
			ST_PAUSE: begin
				if (pause_end) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'd0;
			qcnt_q  <= 3'd0;
			for (int i = 0; i < `REG_COUNT; i++) begin
				regs_q[i] <= `RST_ZERO;
			end
			regs_q[`REG_GDA_LO]   <= `RST_DA_LO;
			regs_q[`REG_GDA_HI]   <= `RST_DA_HI;
			regs_q[`REG_PDA_LO]   <= `RST_DA_LO;
			regs_q[`REG_PDA_HI]   <= `RST_DA_HI;
			regs_q[`REG_GTYPE_OP] <= `RST_GTYPE_OP;
			regs_q[`REG_PTYPE_OP] <= `RST_PTYPE_OP;
		end else begin
			ack_q  <= bus_req & ~ack_q;
			qcnt_q <= tick ? 3'd0 : qcnt_q + 3'd1;
			if (bus_req && !ack_q) begin
				rdata_q <= rd_mux;
			end
			for (int b = 0; b < 4; b++) begin
				if (reg_wr && AVS_BYTEENABLE_I[b]) begin
					regs_q[reg_idx][8*b +: 8] <= AVS_WRITEDATA_I[8*b +: 8];
				end
			end
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			state_q  <= ST_IDLE;
			kind_q   <= K_USER;
			idx_q    <= 4'd0;
			wcnt_q   <= 3'd0;
			frame_q  <= '0;
			second_q <= 1'b0;
			mcast_q  <= 1'b0;
			bcast_q  <= 1'b0;
			vlan_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			if (start_pause) begin
				kind_q  <= sel_glob ? K_GLOBAL : K_PRIO;
				idx_q   <= sel_idx;
				wcnt_q  <= 3'd0;
				frame_q <= new_frame;
				mcast_q <= sel_da[40];
				bcast_q <= &sel_da;
				vlan_q  <= 1'b0;
			end else if (pause_fire) begin
				wcnt_q <= wcnt_q + 3'd1;
			end
			if (user_fire && state_q == ST_IDLE) begin
				kind_q  <= K_USER;
				mcast_q <= USER_TDATA_I[0];
				bcast_q <= &USER_TDATA_I[47:0];
				vlan_q  <= 1'b0;
			end
			if (user_fire) begin
				second_q <= (state_q == ST_IDLE);
			end
			if (user_fire && second_q && state_q == ST_USER) begin
				vlan_q <= ({USER_TDATA_I[39:32], USER_TDATA_I[47:40]} == `VLAN_TPID);
			end
		end
	end

	// Output register and statistics; counters fire when the last word is taken.
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			odata_q  <= 64'd0;
			okeep_q  <= 8'd0;
			ovalid_q <= 1'b0;
			olast_q  <= 1'b0;
			sent_q   <= 9'd0;
			stat_q   <= 6'd0;
		end else begin
			if (user_fire) begin
				odata_q  <= USER_TDATA_I;
				okeep_q  <= USER_TKEEP_I;
				ovalid_q <= 1'b1;
				olast_q  <= USER_TLAST_I;
			end else if (pause_fire) begin
				odata_q  <= frame_q[64*wcnt_q +: 64];
				okeep_q  <= (wcnt_q == `LAST_WORD) ? `LAST_KEEP : `FULL_KEEP;
				ovalid_q <= 1'b1;
				olast_q  <= (wcnt_q == `LAST_WORD);
			end else if (MAC_TREADY_I) begin
				ovalid_q <= 1'b0;
			end
			sent_q <= (out_done && kind_q != K_USER) ? 9'(9'd1 << idx_q) : 9'd0;
			stat_q <= out_done ? {kind_q == K_PRIO, kind_q == K_GLOBAL, vlan_q, bcast_q,
				mcast_q & ~bcast_q, ~mcast_q} : 6'd0;
		end
	end

	assign MAC_TDATA_O       = odata_q;
	assign MAC_TKEEP_O       = okeep_q;
	assign MAC_TVALID_O      = ovalid_q;
	assign MAC_TLAST_O       = olast_q;
	assign PAUSE_SENT_O      = sent_q;
	assign STAT_UNICAST_O    = stat_q[0];
	assign STAT_MULTICAST_O  = stat_q[1];
	assign STAT_BROADCAST_O  = stat_q[2];
	assign STAT_VLAN_O       = stat_q[3];
	assign STAT_PAUSE_O      = stat_q[4];
	assign STAT_USER_PAUSE_O = stat_q[5];

	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence s_last_word;
		pause_end;
	endsequence
	sequence s_last_out;
		MAC_TVALID_O && MAC_TLAST_O && MAC_TKEEP_O == `LAST_KEEP;
	endsequence
	property p_pause_end;
		s_last_word |=> s_last_out ##0 state_q == ST_IDLE;
	endproperty
	a_pause_end: assert property (p_pause_end) else $error("pause frame end wrong");
	property p_global_first;
		(start_pause && sel[8]) |=> kind_q == K_GLOBAL && idx_q == `GLOBAL_IDX;
	endproperty
	a_global_first: assert property (p_global_first) else $error("global not chosen");
	property p_gated;
		(state_q == ST_IDLE && !(|sel)) |=> state_q != ST_PAUSE;
	endproperty
	a_gated: assert property (p_gated) else $error("frame without enabled request");
	property p_no_cut;
		(state_q == ST_USER && !(user_fire && USER_TLAST_I)) |=> state_q != ST_PAUSE;
	endproperty
	a_no_cut: assert property (p_no_cut) else $error("pause cut a user packet");
	property p_gda;
		(start_pause && sel[8]) |=> frame_q[7:0] == $past(gda[47:40]) && frame_q[15:8] ==
			$past(gda[39:32]);
	endproperty
	a_gda: assert property (p_gda) else $error("global address wrong");
	property p_pda;
		(start_pause && !sel[8]) |=> frame_q[7:0] == $past(pda[47:40]);
	endproperty
	a_pda: assert property (p_pda) else $error("priority address wrong");
	property p_sent_one;
		$onehot0(PAUSE_SENT_O) && (|PAUSE_SENT_O == (STAT_PAUSE_O | STAT_USER_PAUSE_O));
	endproperty
	a_sent_one: assert property (p_sent_one) else $error("sent flag mismatch");
	property p_cast;
		(STAT_UNICAST_O | STAT_MULTICAST_O | STAT_BROADCAST_O) |-> $past(out_done) &&
			$onehot({STAT_UNICAST_O, STAT_MULTICAST_O, STAT_BROADCAST_O});
	endproperty
	a_cast: assert property (p_cast) else $error("address class pulse wrong");
	property p_glob_stat;
		PAUSE_SENT_O[8] |-> STAT_PAUSE_O && !STAT_USER_PAUSE_O;
	endproperty
	a_glob_stat: assert property (p_glob_stat) else $error("global count missed");
	property p_prio_stat;
		(|PAUSE_SENT_O[7:0]) |-> STAT_USER_PAUSE_O && !STAT_PAUSE_O;
	endproperty
	a_prio_stat: assert property (p_prio_stat) else $error("priority count missed");

endmodule

/* File: inc/tx_pause_params.svh */
`ifndef TX_PAUSE_PARAMS_SVH
`define TX_PAUSE_PARAMS_SVH

// Register word indices; the byte address is four times the index.
`define REG_PAUSE_EN     4'd0
`define REG_QUANTA45     4'd1
`define REG_GDA_LO       4'd2
`define REG_GDA_HI       4'd3
`define REG_GSA_LO       4'd4
`define REG_GSA_HI       4'd5
`define REG_GTYPE_OP     4'd6
`define REG_PDA_LO       4'd7
`define REG_PDA_HI       4'd8
`define REG_PSA_LO       4'd9
`define REG_PSA_HI       4'd10
`define REG_PTYPE_OP     4'd11
`define REG_STATUS       4'd12
`define REG_COUNT        12

// Reset values of the writable registers.
`define RST_ZERO         32'h0000_0000
`define RST_DA_LO        32'hc200_0001
`define RST_DA_HI        32'h0000_0180
`define RST_GTYPE_OP     32'h0001_8808
`define RST_PTYPE_OP     32'h0101_8808

// Frame layout and timing.
`define QUANTUM_BITS     512
`define WORD_BITS        64
`define QUANTUM_CYCLES   (`QUANTUM_BITS / `WORD_BITS)
`define FRAME_WORDS      8
`define LAST_WORD        3'd7
`define FULL_KEEP        8'hff
`define LAST_KEEP        8'h0f
`define VLAN_TPID        16'h8100
`define GLOBAL_IDX       4'd8

`endif

/* File: inc/tx_pause_pkg.sv */
package tx_pause_pkg;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_PAUSE = 2'b01,
		ST_USER  = 2'b10
	} sched_state_t;

	typedef enum logic [1:0] {
		K_USER   = 2'b00,
		K_GLOBAL = 2'b01,
		K_PRIO   = 2'b10
	} frame_kind_t;

endpackage

/* File: verification/mac_sink_model.sv */
`timescale 1ns/1ns
module mac_sink_model (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Pacing of the sink.
	input  wire logic        stall_i,
	// Stream from the block.
	input  wire logic [63:0] tdata_i,
	input  wire logic [7:0]  tkeep_i,
	input  wire logic        tvalid_i,
	input  wire logic        tlast_i,
	output logic             tready_o
);
	logic [7:0] got[$];
	int         n_frames;

	initial begin
		tready_o = 1'b0;
		n_frames = 0;
	end

	// With stall_i set the sink drops ready at random, so the block must hold every word it offers.
	always @(posedge clk_i) begin
		if (rst_i) begin
			tready_o <= 1'b0;
		end else begin
			if (tvalid_i === 1'b1 && tready_o) begin
				for (int b = 0; b < 8; b++)
					if (tkeep_i[b]) got.push_back(tdata_i[8*b +: 8]);
				if (tlast_i) n_frames++;
			end
			tready_o <= stall_i ? 1'($urandom_range(1)) : 1'b1;
		end
	end
endmodule

/* File: verification/tx_pause_frame_generator_tb_top.sv */
`timescale 1ns/1ns
module tx_pause_frame_generator_tb_top;
	logic             CLOCK_I, SYS_RST_I, AVS_READ_I, AVS_WRITE_I, RESEND_PAUSE_I, stall;
	logic             USER_TVALID_I, USER_TLAST_I, MAC_TREADY_I, USER_TREADY_O;
	logic             MAC_TVALID_O, MAC_TLAST_O, AVS_WAITREQUEST_O;
	logic             STAT_UNICAST_O, STAT_MULTICAST_O, STAT_BROADCAST_O;
	logic             STAT_VLAN_O, STAT_PAUSE_O, STAT_USER_PAUSE_O;
	logic [5:0]       AVS_ADDRESS_I;
	logic [3:0]       AVS_BYTEENABLE_I;
	logic [31:0]      AVS_WRITEDATA_I, AVS_READDATA_O, rd;
	logic [8:0]       PAUSE_REQ_I, PAUSE_ENABLE_I, PAUSE_SENT_O;
	logic [8:0][15:0] PAUSE_QUANTA_I, REFRESH_TIMER_I;
	logic [47:0]      GLOBAL_FRAME_DEST_ADDR_I, GLOBAL_FRAME_SRC_ADDR_I;
	logic [47:0]      PRIORITY_FRAME_DEST_ADDR_I, PRIORITY_FRAME_SRC_ADDR_I;
	logic [15:0]      GLOBAL_ETHERTYPE_I, GLOBAL_OPCODE_I, PRIORITY_ETHERTYPE_I, PRIORITY_OPCODE_I;
	logic [63:0]      USER_TDATA_I, MAC_TDATA_O;
	logic [7:0]       USER_TKEEP_I, MAC_TKEEP_O, exp[$];
	logic [31:0]      sh[16];
	int               cnt[15], ec[15], n_errors, n_compared, base;
	wire  [14:0]      pulses = {STAT_USER_PAUSE_O, STAT_PAUSE_O, STAT_VLAN_O, STAT_BROADCAST_O,
		STAT_MULTICAST_O, STAT_UNICAST_O, PAUSE_SENT_O};

	tx_pause_frame_generator #(.REG_MAP(1'b1)) uut (
		.CLOCK_I, .SYS_RST_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I,
		.AVS_BYTEENABLE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .PAUSE_REQ_I, .PAUSE_ENABLE_I,
		.RESEND_PAUSE_I, .PAUSE_QUANTA_I, .REFRESH_TIMER_I, .GLOBAL_FRAME_DEST_ADDR_I,
		.GLOBAL_FRAME_SRC_ADDR_I, .GLOBAL_ETHERTYPE_I, .GLOBAL_OPCODE_I,
		.PRIORITY_FRAME_DEST_ADDR_I, .PRIORITY_FRAME_SRC_ADDR_I, .PRIORITY_ETHERTYPE_I,
		.PRIORITY_OPCODE_I, .USER_TDATA_I, .USER_TKEEP_I, .USER_TVALID_I, .USER_TLAST_I,
		.USER_TREADY_O, .MAC_TDATA_O, .MAC_TKEEP_O, .MAC_TVALID_O, .MAC_TLAST_O, .MAC_TREADY_I,
		.PAUSE_SENT_O, .STAT_UNICAST_O, .STAT_MULTICAST_O, .STAT_BROADCAST_O, .STAT_VLAN_O,
		.STAT_PAUSE_O, .STAT_USER_PAUSE_O
	);
	mac_sink_model sink (
		.clk_i(CLOCK_I), .rst_i(SYS_RST_I), .stall_i(stall), .tdata_i(MAC_TDATA_O),
		.tkeep_i(MAC_TKEEP_O), .tvalid_i(MAC_TVALID_O), .tlast_i(MAC_TLAST_O),
		.tready_o(MAC_TREADY_I)
	);

	initial begin
		CLOCK_I = 1'b0;
		forever #4 CLOCK_I = ~CLOCK_I;
	end

	// An unknown pulse is counted as a pulse so that it can never pass unnoticed.
	always @(posedge CLOCK_I) begin
		if (!SYS_RST_I)
			foreach (cnt[i]) if (pulses[i] !== 1'b0) cnt[i]++;
	end

	task automatic chk(string nm, logic [63:0] seen, logic [63:0] want);
		n_compared++;
		if (seen !== want) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, want, seen);
		end
	endtask

	task automatic final_report();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic bus(bit wr, int idx, logic [31:0] d, logic [3:0] be);
		@(posedge CLOCK_I);
		AVS_ADDRESS_I <= 6'(idx * 4);
		AVS_WRITE_I <= wr;
		AVS_READ_I <= !wr;
		AVS_WRITEDATA_I <= d;
		AVS_BYTEENABLE_I <= be;
		do @(posedge CLOCK_I); while (AVS_WAITREQUEST_O !== 1'b0);
		if (!wr) rd = AVS_READDATA_O;
		AVS_WRITE_I <= 1'b0;
		AVS_READ_I <= 1'b0;
		if (wr && idx < 12)
			for (int b = 0; b < 4; b++) if (be[b]) sh[idx][8*b +: 8] = d[8*b +: 8];
	endtask

	task automatic sweep();
		for (int i = 0; i < 16; i++) begin
			bus(1'b0, i, 32'h0, 4'hf);
			chk($sformatf("reg %0d", i), rd, sh[i]);
		end
	endtask

	function automatic void count_da(logic [47:0] da);
		ec[da == 48'hffff_ffff_ffff ? 11 : (da[40] ? 10 : 9)]++;
	endfunction

	function automatic void exp_pause(int idx);
		int           b = idx == 8 ? 2 : 7;
		int           k = idx == 8 ? 16 : 18 + 2 * idx;
		logic [15:0]  q = idx == 4 ? sh[1][15:0] : idx == 5 ? sh[1][31:16] : PAUSE_QUANTA_I[idx];
		logic [127:0] h = {sh[b+1][15:0], sh[b], sh[b+3][15:0], sh[b+2], sh[b+4][15:0],
			sh[b+4][31:16]};
		for (int i = 0; i < 60; i++)
			exp.push_back(i < 16 ? h[127-8*i -: 8] : i == k ? q[15:8] : i == k + 1 ? q[7:0] :
				(i == 17 && idx < 8) ? 8'(1 << idx) : 8'h00);
		count_da(h[127:80]);
		ec[idx]++;
		ec[idx == 8 ? 13 : 14]++;
	endfunction

	task automatic wait_frames(int n);
		int t = sink.n_frames + n;
		while (sink.n_frames < t) @(posedge CLOCK_I);
		repeat (2) @(posedge CLOCK_I);
		chk("frames", sink.n_frames, t);
	endtask

	task automatic cmp_all();
		while (exp.size() > 0)
			chk("byte", sink.got.size() ? sink.got.pop_front() : 8'hxx, exp.pop_front());
		chk("extra bytes", sink.got.size(), 0);
		foreach (cnt[i]) chk($sformatf("pulse %0d", i), cnt[i], ec[i]);
	endtask

	task automatic pulse_resend();
		RESEND_PAUSE_I <= 1'b1;
		@(posedge CLOCK_I);
		RESEND_PAUSE_I <= 1'b0;
	endtask

	task automatic send_user(logic [47:0] da, bit vlan, bit prq);
		logic [7:0]  f[64];
		logic [63:0] d;
		foreach (f[i]) f[i] = 8'($urandom);
		for (int i = 0; i < 6; i++) f[i] = da[47-8*i -: 8];
		{f[12], f[13]} = vlan ? 16'h8100 : 16'h0800;
		foreach (f[i]) exp.push_back(f[i]);
		count_da(da);
		ec[12] += vlan;
		for (int w = 0; w < 8; w++) begin
			for (int b = 0; b < 8; b++) d[8*b +: 8] = f[8*w+b];
			USER_TDATA_I <= d;
			USER_TKEEP_I <= 8'hff;
			USER_TVALID_I <= 1'b1;
			USER_TLAST_I <= (w == 7);
			PAUSE_REQ_I <= (prq && w == 2) ? 9'h004 : 9'h000;
			do @(posedge CLOCK_I); while (USER_TREADY_O !== 1'b1);
		end
		// A pause asked for mid-packet must wait until this packet has gone.
		if (prq) exp_pause(2);
	endtask

	initial begin
		repeat (20000) @(posedge CLOCK_I);
		n_errors++;
		final_report();
	end

	initial begin
		void'($urandom(32'h17a4));
		{AVS_READ_I, AVS_WRITE_I, RESEND_PAUSE_I, USER_TVALID_I, USER_TLAST_I} = '0;
		{AVS_ADDRESS_I, AVS_WRITEDATA_I, USER_TDATA_I, USER_TKEEP_I, PAUSE_REQ_I} = '0;
		AVS_BYTEENABLE_I = 4'hf;
		stall = 1'b1;
		// The pin copies of the settings get noise, since the register map must win.
		PAUSE_ENABLE_I = 9'($urandom);
		{GLOBAL_FRAME_DEST_ADDR_I, GLOBAL_FRAME_SRC_ADDR_I, PRIORITY_FRAME_DEST_ADDR_I,
			PRIORITY_FRAME_SRC_ADDR_I} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
		{GLOBAL_ETHERTYPE_I, GLOBAL_OPCODE_I, PRIORITY_ETHERTYPE_I, PRIORITY_OPCODE_I} =
			{$urandom, $urandom};
		foreach (PAUSE_QUANTA_I[i]) PAUSE_QUANTA_I[i] = 16'($urandom);
		foreach (REFRESH_TIMER_I[i]) REFRESH_TIMER_I[i] = 16'hffff;
		foreach (sh[i]) sh[i] = 32'h0;
		sh[2] = 32'hc200_0001;
		sh[3] = 32'h0000_0180;
		sh[7] = 32'hc200_0001;
		sh[8] = 32'h0000_0180;
		sh[6] = 32'h0001_8808;
		sh[11] = 32'h0101_8808;
		SYS_RST_I = 1'b1;
		repeat (8) @(posedge CLOCK_I);
		SYS_RST_I <= 1'b0;
		sweep();
		bus(1'b1, 0, 32'h0000_01df, 4'hf);
		bus(1'b1, 1, $urandom, 4'hf);
		bus(1'b1, 4, $urandom, 4'b0101);
		bus(1'b1, 5, $urandom & 32'hffff, 4'hf);
		bus(1'b1, 9, $urandom, 4'hf);
		bus(1'b1, 10, $urandom & 32'hffff, 4'hf);
		bus(1'b1, 12, $urandom, 4'hf);
		bus(1'b1, 14, $urandom, 4'hf);
		sweep();
		// All nine at once: global first, then rising priority, index 5 stays silent.
		PAUSE_REQ_I <= 9'h1ff;
		@(posedge CLOCK_I);
		PAUSE_REQ_I <= 9'h000;
		foreach (ec[i]) if (i == 8) exp_pause(8);
		for (int i = 0; i < 8; i++) if (i != 5) exp_pause(i);
		wait_frames(8);
		cmp_all();
		REFRESH_TIMER_I[0] <= 16'd2;
		PAUSE_REQ_I <= 9'h001;
		base = sink.n_frames;
		wait_frames(2);
		PAUSE_REQ_I <= 9'h000;
		REFRESH_TIMER_I[0] <= 16'hffff;
		repeat (100) @(posedge CLOCK_I);
		base = sink.n_frames - base;
		chk("refresh frames", base inside {[2:3]}, 1);
		repeat (base) exp_pause(0);
		cmp_all();
		stall <= 1'b0;
		PAUSE_REQ_I <= 9'h002;
		wait_frames(1);
		pulse_resend();
		wait_frames(1);
		PAUSE_REQ_I <= 9'h000;
		repeat (2) exp_pause(1);
		cmp_all();
		stall <= 1'b1;
		send_user(48'hffff_ffff_ffff, 1'b1, 1'b0);
		send_user({8'h02, 8'($urandom), 32'($urandom)}, 1'b0, 1'b0);
		send_user({8'h01, 8'($urandom), 32'($urandom)}, 1'b1, 1'b1);
		USER_TVALID_I <= 1'b0;
		// The last packet and the pause frame held back behind it are both still to come.
		wait_frames(2);
		cmp_all();
		final_report();
	end
endmodule
